// [src/ampc_regs.svh]
/*
  Register pointers, field positions, reset values and fixed numbers of
  the amplifier control slave. Assumes a single includer per compile unit
  or relies on the guard below.
*/
`ifndef AMPC_REGS_SVH
`define AMPC_REGS_SVH

// ==========================================================
// Register pointers
`define AMPC_PTR_STATUS 8'h00
`define AMPC_PTR_MUTE 8'h01
`define AMPC_PTR_PWR 8'h02
`define AMPC_PTR_CFG 8'h03

// ==========================================================
// Field positions
`define AMPC_MUTE_R_BIT 4
`define AMPC_MUTE_L_BIT 3
`define AMPC_PWR_DOWN_BIT 0
`define AMPC_PWR_RST_HI 7
`define AMPC_PWR_RST_LO 2
`define AMPC_CFG_MODE_BIT 4
`define AMPC_CFG_GAIN_BIT 3
`define AMPC_CFG_AUTO_DIS_BIT 2
`define AMPC_CFG_INSRC_BIT 1

// ==========================================================
// Reset values and fixed codes
`define AMPC_MUTE_RST 8'h00
`define AMPC_PWR_RST 8'h00
`define AMPC_CFG_RST 8'h00
`define AMPC_RST_PATTERN 6'h3F
`define AMPC_ADDR_FIXED 5'h12
`define AMPC_BYTE_BITS 4'h8
`define AMPC_ZERO_BYTE 8'h00

// ==========================================================
// Thermal limits in degrees C (160 trip, 15 hysteresis)
`define AMPC_THERM_TRIP_C 8'hA0
`define AMPC_THERM_HYST_C 8'h0F

`endif

// [src/ampc_pkg.sv]
/*
  Types of the amplifier control slave: link states and the sense and
  control pin bundles. Assumes nothing outside itself.
*/
package ampc_pkg;

  // ==========================================================
  // Serial link states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_ADDR  = 4'h1,
    ST_AACK  = 4'h2,
    ST_PTR   = 4'h3,
    ST_PACK  = 4'h4,
    ST_WDATA = 4'h5,
    ST_WACK  = 4'h6,
    ST_RDATA = 4'h7,
    ST_RACK  = 4'h8
  } ampc_state_t;

  // ==========================================================
  // Analog sense inputs
  typedef struct packed {
    logic [7:0] die_temp_c;
    logic right_neg_overcurrent;
    logic right_pos_overcurrent;
    logic left_neg_overcurrent;
    logic left_pos_overcurrent;
  } ampc_sense_t;

  // Amplifier control outputs
  typedef struct packed {
    logic left_channel_silence;
    logic right_channel_silence;
    logic power_down;
    logic input_source_select;
    logic gain_setting_select;
    logic headphone_mode_flag;
    logic inverting_out_disable;
    logic output_stage_enable;
  } ampc_ctrl_t;

endpackage

// [src/ampc_i2c_regs.sv]
/*
  Two-wire control slave of a stereo amplifier with its four registers,
  headphone-sense interrupt and thermal cut-out. Assumes link_clk is a
  free-running oversampling clock well above the serial clock rate, that
  the die temperature word comes from logic on ref_clk, and that the
  open-drain lines are resolved outside from sda_o and sda_oe.
*/
`timescale 1ns/1ps
`include "ampc_regs.svh"

module ampc_i2c_regs
  import ampc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [1:0] addr_strap,
  input wire logic headphone_sense_in,
  input wire ampc_sense_t sense_in,
  output logic sda_o,
  output logic sda_oe,
  output logic int_n,
  output ampc_ctrl_t ctrl
);

  // ==========================================================
  // Link-domain state record
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic scl_f;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic sda_f;
    logic strap_ok;
    logic [1:0] strap;
    ampc_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic rw;
    logic [7:0] ptr;
    logic [3:0][7:0] regs;
    logic [5:0] st_s1;
    logic [5:0] st_s2;
    logic rd_tgl;
    logic sda_oe;
    logic sda_o;
  } ampc_link_t;

  // Reference-domain state record
  typedef struct packed {
    logic [6:0] ctl_s1;
    logic [6:0] ctl_s2;
    logic hps_s1;
    logic hps_s2;
    logic hps_s3;
    logic hps_f;
    logic hps_ok;
    logic [3:0] ovc_s1;
    logic [3:0] ovc_s2;
    logic [3:0] ovc_s3;
    logic [3:0] ovc_f;
    logic rdt_s1;
    logic rdt_s2;
    logic rdt_s3;
    logic over_temp;
    logic [5:0] st_bits;
    logic int_n;
    ampc_ctrl_t ctrl;
  } ampc_ref_t;

  ampc_link_t l_r;
  ampc_link_t l_nxt;
  ampc_ref_t r_r;
  ampc_ref_t r_nxt;

  // ==========================================================
  // Link domain: line filtering, framing and register file
  always_comb begin
    logic scl_new;
    logic sda_new;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [7:0] rd_byte;
    scl_new = 1'b0;
    sda_new = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    rd_byte = `AMPC_ZERO_BYTE;
    l_nxt = l_r;

    // Reset and line synchronisers
    l_nxt.rst_s1 = reset_n;
    l_nxt.rst_s2 = l_r.rst_s1;
    l_nxt.scl_s1 = scl_i;
    l_nxt.scl_s2 = l_r.scl_s1;
    l_nxt.scl_s3 = l_r.scl_s2;
    l_nxt.sda_s1 = sda_i;
    l_nxt.sda_s2 = l_r.sda_s1;
    l_nxt.sda_s3 = l_r.sda_s2;
    l_nxt.st_s1 = r_r.st_bits;
    l_nxt.st_s2 = l_r.st_s1;

    // A change counts once two stages agree
    scl_new = (l_r.scl_s2 == l_r.scl_s3) ? l_r.scl_s2 : l_r.scl_f;
    sda_new = (l_r.sda_s2 == l_r.sda_s3) ? l_r.sda_s2 : l_r.sda_f;
    l_nxt.scl_f = scl_new;
    l_nxt.sda_f = sda_new;
    rise = !l_r.scl_f && scl_new;
    fall = l_r.scl_f && !scl_new;
    start = l_r.scl_f && scl_new && l_r.sda_f && !sda_new;
    stop = l_r.scl_f && scl_new && !l_r.sda_f && sda_new;

    // Read mux over the selected pointer
    if (l_r.ptr == `AMPC_PTR_STATUS) begin
      rd_byte = {l_r.st_s2, 2'h0};
    end else if (l_r.ptr == `AMPC_PTR_MUTE) begin
      rd_byte = l_r.regs[1];
    end else if (l_r.ptr == `AMPC_PTR_PWR) begin
      rd_byte = l_r.regs[2];
    end else if (l_r.ptr == `AMPC_PTR_CFG) begin
      rd_byte = l_r.regs[3];
    end else begin
      rd_byte = `AMPC_ZERO_BYTE;
    end

    if (!l_r.rst_s2) begin
      l_nxt.state = ST_IDLE;
      l_nxt.bitcnt = 4'h0;
      l_nxt.shift = `AMPC_ZERO_BYTE;
      l_nxt.rw = 1'b0;
      l_nxt.ptr = `AMPC_PTR_STATUS;
      l_nxt.regs = {`AMPC_CFG_RST, `AMPC_PWR_RST, `AMPC_MUTE_RST, `AMPC_ZERO_BYTE};
      l_nxt.strap_ok = 1'b0;
      l_nxt.strap = 2'h0;
      l_nxt.rd_tgl = 1'b0;
      l_nxt.sda_oe = 1'b0;
      l_nxt.sda_o = 1'b0;
    end else begin
      // Strap caught once after reset release
      if (!l_r.strap_ok) begin
        l_nxt.strap = addr_strap;
        l_nxt.strap_ok = 1'b1;
      end
      // Start and stop override any state
      if (start) begin
        l_nxt.state = ST_ADDR;
        l_nxt.bitcnt = 4'h0;
        l_nxt.sda_oe = 1'b0;
      end else if (stop) begin
        l_nxt.state = ST_IDLE;
        l_nxt.sda_oe = 1'b0;
      end else begin
        case (l_r.state)
          ST_IDLE: begin
            l_nxt.sda_oe = 1'b0;
          end
          ST_ADDR, ST_PTR, ST_WDATA: begin
            // Receive a byte, MSB first
            if (rise) begin
              l_nxt.shift = {l_r.shift[6:0], sda_new};
              l_nxt.bitcnt = l_r.bitcnt + 4'h1;
            end else if (fall && l_r.bitcnt == `AMPC_BYTE_BITS) begin
              l_nxt.bitcnt = 4'h0;
              if (l_r.state == ST_ADDR) begin
                // Own address only; general call and 10-bit never match
                if (l_r.shift[7:1] == {`AMPC_ADDR_FIXED, l_r.strap}) begin
                  l_nxt.rw = l_r.shift[0];
                  l_nxt.sda_oe = 1'b1;
                  l_nxt.state = ST_AACK;
                end else begin
                  l_nxt.state = ST_IDLE;
                end
              end else if (l_r.state == ST_PTR) begin
                l_nxt.ptr = l_r.shift;
                l_nxt.sda_oe = 1'b1;
                l_nxt.state = ST_PACK;
              end else begin
                // Data byte lands in the pointed register, except the PWR reset pattern, which reloads all registers
                if (l_r.ptr == `AMPC_PTR_MUTE) begin
                  l_nxt.regs[1] = l_r.shift;
                end else if (l_r.ptr == `AMPC_PTR_PWR) begin
                  if (l_r.shift[`AMPC_PWR_RST_HI:`AMPC_PWR_RST_LO] == `AMPC_RST_PATTERN) begin
                    l_nxt.regs = {`AMPC_CFG_RST, `AMPC_PWR_RST, `AMPC_MUTE_RST, `AMPC_ZERO_BYTE};
                  end else begin
                    l_nxt.regs[2] = l_r.shift;
                  end
                end else if (l_r.ptr == `AMPC_PTR_CFG) begin
                  l_nxt.regs[3] = l_r.shift;
                end
                l_nxt.sda_oe = 1'b1;
                l_nxt.state = ST_WACK;
              end
            end
          end
          ST_AACK: begin
            // End of address acknowledge: turn round on read
            if (fall) begin
              if (l_r.rw) begin
                l_nxt.shift = rd_byte;
                l_nxt.sda_oe = !rd_byte[7];
                l_nxt.bitcnt = 4'h0;
                l_nxt.state = ST_RDATA;
              end else begin
                l_nxt.sda_oe = 1'b0;
                l_nxt.state = ST_PTR;
              end
            end
          end
          ST_PACK, ST_WACK: begin
            // Further bytes keep writing the same pointer
            if (fall) begin
              l_nxt.sda_oe = 1'b0;
              l_nxt.state = ST_WDATA;
            end
          end
          ST_RDATA: begin
            // Shift out on falling edges
            if (rise) begin
              l_nxt.bitcnt = l_r.bitcnt + 4'h1;
            end else if (fall) begin
              if (l_r.bitcnt == `AMPC_BYTE_BITS) begin
                l_nxt.sda_oe = 1'b0;
                l_nxt.rd_tgl = !l_r.rd_tgl;
                l_nxt.state = ST_RACK;
              end else begin
                l_nxt.shift = {l_r.shift[6:0], 1'b0};
                l_nxt.sda_oe = !l_r.shift[6];
              end
            end
          end
          ST_RACK: begin
            // Master ack repeats the byte, nack ends the read
            if (rise && sda_new) begin
              l_nxt.state = ST_IDLE;
            end else if (fall) begin
              l_nxt.shift = rd_byte;
              l_nxt.sda_oe = !rd_byte[7];
              l_nxt.bitcnt = 4'h0;
              l_nxt.state = ST_RDATA;
            end
          end
          default: begin
            l_nxt.state = ST_IDLE;
            l_nxt.sda_oe = 1'b0;
          end
        endcase
      end
    end
  end

  // Link-domain register stage
  always_ff @(posedge link_clk) begin
    l_r <= l_nxt;
  end

  // ==========================================================
  // Reference domain: mode, thermal and interrupt logic
  always_comb begin
    logic auto_dis;
    logic hp_mode;
    logic pdown;
    logic sense_evt;
    logic rd_evt;
    logic [3:0] ovc_in;
    auto_dis = 1'b0;
    hp_mode = 1'b0;
    pdown = 1'b0;
    sense_evt = 1'b0;
    rd_evt = 1'b0;
    ovc_in = {sense_in.right_neg_overcurrent, sense_in.right_pos_overcurrent,
              sense_in.left_neg_overcurrent, sense_in.left_pos_overcurrent};
    r_nxt = r_r;

    // Register bits cross as independent levels
    r_nxt.ctl_s1 = {l_r.regs[1][`AMPC_MUTE_L_BIT], l_r.regs[1][`AMPC_MUTE_R_BIT],
                    l_r.regs[2][`AMPC_PWR_DOWN_BIT], l_r.regs[3][`AMPC_CFG_INSRC_BIT],
                    l_r.regs[3][`AMPC_CFG_GAIN_BIT], l_r.regs[3][`AMPC_CFG_AUTO_DIS_BIT],
                    l_r.regs[3][`AMPC_CFG_MODE_BIT]};
    r_nxt.ctl_s2 = r_r.ctl_s1;

    // Pin synchronisers with agreement filter
    r_nxt.hps_s1 = headphone_sense_in;
    r_nxt.hps_s2 = r_r.hps_s1;
    r_nxt.hps_s3 = r_r.hps_s2;
    r_nxt.ovc_s1 = ovc_in;
    r_nxt.ovc_s2 = r_r.ovc_s1;
    r_nxt.ovc_s3 = r_r.ovc_s2;
    r_nxt.ovc_f = (r_r.ovc_s2 & r_r.ovc_s3) | (r_r.ovc_f & (r_r.ovc_s2 ^ r_r.ovc_s3));
    r_nxt.rdt_s1 = l_r.rd_tgl;
    r_nxt.rdt_s2 = r_r.rdt_s1;
    r_nxt.rdt_s3 = r_r.rdt_s2;
    rd_evt = r_r.rdt_s2 ^ r_r.rdt_s3;

    auto_dis = r_r.ctl_s2[1];
    pdown = r_r.ctl_s2[4];
    if (r_r.hps_s2 == r_r.hps_s3) begin
      r_nxt.hps_f = r_r.hps_s2;
      r_nxt.hps_ok = 1'b1;
      // First settled sample is not a change
      sense_evt = r_r.hps_ok && (r_r.hps_s2 != r_r.hps_f) && !auto_dis;
    end

    // Mode from sense pin or from the mode bit
    hp_mode = auto_dis ? r_r.ctl_s2[0] : r_r.hps_f;

    // Thermal cut-out with hysteresis
    if (sense_in.die_temp_c > `AMPC_THERM_TRIP_C) begin
      r_nxt.over_temp = 1'b1;
    end else if (sense_in.die_temp_c <= `AMPC_THERM_TRIP_C - `AMPC_THERM_HYST_C) begin
      r_nxt.over_temp = 1'b0;
    end

    // Status word seen by the link side
    r_nxt.st_bits = {r_r.over_temp, r_r.ovc_f, hp_mode};

    // Interrupt: a new change wins over a read release
    if (sense_evt) begin
      r_nxt.int_n = 1'b0;
    end else if (rd_evt) begin
      r_nxt.int_n = 1'b1;
    end

    // Amplifier controls
    r_nxt.ctrl.left_channel_silence = r_r.ctl_s2[6];
    r_nxt.ctrl.right_channel_silence = r_r.ctl_s2[5];
    r_nxt.ctrl.power_down = pdown;
    r_nxt.ctrl.input_source_select = r_r.ctl_s2[3];
    r_nxt.ctrl.gain_setting_select = auto_dis ? r_r.ctl_s2[2] : 1'b0;
    r_nxt.ctrl.headphone_mode_flag = hp_mode;
    r_nxt.ctrl.inverting_out_disable = hp_mode;
    r_nxt.ctrl.output_stage_enable = !r_r.over_temp && !pdown;

    if (!reset_n) begin
      r_nxt.hps_f = 1'b0;
      r_nxt.hps_ok = 1'b0;
      r_nxt.ovc_f = 4'h0;
      r_nxt.rdt_s1 = 1'b0;
      r_nxt.rdt_s2 = 1'b0;
      r_nxt.rdt_s3 = 1'b0;
      r_nxt.over_temp = 1'b0;
      r_nxt.st_bits = 6'h00;
      r_nxt.int_n = 1'b1;
      r_nxt.ctrl = '0;
    end
  end

  // Reference-domain register stage
  always_ff @(posedge ref_clk) begin
    r_r <= r_nxt;
  end

  // ==========================================================
  // Outputs straight from flops
  assign sda_o = l_r.sda_o;
  assign sda_oe = l_r.sda_oe;
  assign int_n = r_r.int_n;
  assign ctrl = r_r.ctrl;

endmodule

// [test/ampc_master_model.sv]
/* Two-wire bus master model for the control slave.
   Assumes the bench pulls the data wire up when released. */
`timescale 1ns/1ps
module ampc_master_model (
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // ========
  // Quarter bit time
  localparam time Q = 100;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // One clock pulse, data set while clock low
  task automatic cyc(input logic b, output logic s);
    sda_pull = !b;
    #Q scl = 1'b1;
    #Q s = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  // Start or repeated start
  task automatic start_c();
    sda_pull = 1'b0;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  // Stop, data rises with clock high
  task automatic stop_c();
    sda_pull = 1'b1;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b0;
    #Q;
  endtask
  // Byte out, MSB first, returns acknowledge
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) cyc(b[i], s);
    cyc(1'b1, s);
    ack = !s;
  endtask
  // Byte in, last one not acknowledged
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      cyc(1'b1, s);
      b[i] = s;
    end
    cyc(last, s);
  endtask
endmodule

// [test/ampc_i2c_regs_assertions.sv]
/* Port checks of the amplifier control slave.
   Assumes one reset for both clock domains. */
`timescale 1ns/1ps
module ampc_i2c_regs_assertions
  import ampc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [1:0] addr_strap,
  input wire logic headphone_sense_in,
  input wire ampc_sense_t sense_in,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic int_n,
  input wire ampc_ctrl_t ctrl
);
  // ========
  // Ages since data drive and since sense change
  logic [6:0] oe_age_r;
  logic [6:0] chg_age_r;
  logic hp_d_r;
  always_ff @(posedge ref_clk) begin
    hp_d_r <= headphone_sense_in;
    if (!reset_n) oe_age_r <= 7'h7F;
    else if (sda_oe) oe_age_r <= 7'h00;
    else if (oe_age_r != 7'h7F) oe_age_r <= oe_age_r + 7'h01;
    if (!reset_n) chg_age_r <= 7'h7F;
    else if (headphone_sense_in != hp_d_r) chg_age_r <= 7'h00;
    else if (chg_age_r != 7'h7F) chg_age_r <= chg_age_r + 7'h01;
  end
  // ========
  // Link side
  AST_SDA_LOW: assert property (@(posedge link_clk) disable iff (!reset_n)
    sda_oe |-> !sda_o) else $error("data drive not low");
  AST_OE_SCL_LOW: assert property (@(posedge link_clk) disable iff (!reset_n)
    $rose(sda_oe) |-> !scl_i) else $error("data driven in clock high");
  AST_OE_STABLE: assert property (@(posedge link_clk) disable iff (!reset_n)
    scl_i [*6] |-> $stable(sda_oe)) else $error("data moved in clock high");
  // Control side
  AST_OUT_HOT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (sense_in.die_temp_c > 8'hA0) [*8] |-> !ctrl.output_stage_enable) else $error("stage on when hot");
  AST_POWER_DOWN_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ctrl.power_down [*2] |-> !ctrl.output_stage_enable) else $error("stage on in shutdown");
  AST_HP_INV: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ctrl.inverting_out_disable == ctrl.headphone_mode_flag)
    else $error("inverting output wrong");
  AST_INT_FALL: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(int_n) |-> chg_age_r <= 7'h0C) else $error("interrupt without sense change");
  AST_INT_REL: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(int_n) |-> oe_age_r <= 7'h3C) else $error("interrupt freed without read");
  // Silence, power, source and gain bits move only by bus writes
  AST_CTRL_BUS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !$stable(ctrl[7:3]) |-> oe_age_r <= 7'h3C) else $error("control moved without bus");
  cover property (@(posedge ref_clk) disable iff (!reset_n) $fell(int_n));
  cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(ctrl.power_down));
  cover property (@(posedge ref_clk) disable iff (!reset_n) $rose(ctrl.headphone_mode_flag));
  cover property (@(posedge ref_clk) disable iff (!reset_n) $fell(ctrl.output_stage_enable) && !ctrl.power_down);
endmodule
bind ampc_i2c_regs ampc_i2c_regs_assertions u_ampc_i2c_regs_assertions (.ref_clk, .reset_n, .link_clk,
  .scl_i, .sda_i, .addr_strap, .headphone_sense_in, .sense_in, .sda_o, .sda_oe, .int_n, .ctrl);

// [test/ampc_i2c_regs_tb.sv]
/* Self-checking bench of the amplifier control slave.
   Assumes the master model and the bound checker. */
`timescale 1ns/1ps
module ampc_i2c_regs_tb
  import ampc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic hp = 1'b0;
  logic [1:0] strap = 2'h2;
  ampc_sense_t sense = 12'h190;
  logic scl, m_pull, sda_o, sda_oe, int_n, ot = 1'b0, ie = 1'b1;
  wire sda;
  ampc_ctrl_t ctrl;
  logic [7:0] mdl [4] = '{default: 8'h00};
  logic [7:0] msk [4] = '{8'hFC, 8'h18, 8'h01, 8'h1E};
  logic [7:0] tmp [4] = '{8'hA0, 8'hA1, 8'h92, 8'h91};
  logic [31:0] lfsr = 32'hB4128641;
  int err_total = 0;
  int samples_checked = 0;
  // ========
  // Clocks and pulled-up data wire
  always #50 ref_clk = !ref_clk;
  always #3 link_clk = !link_clk;
  assign sda = !(m_pull || (sda_oe && !sda_o));
  ampc_master_model mst (.scl(scl), .sda_pull(m_pull), .sda(sda));
  ampc_i2c_regs u_ampc_i2c_regs (.ref_clk(ref_clk), .reset_n(reset_n), .link_clk(link_clk),
    .scl_i(scl), .sda_i(sda), .addr_strap(strap), .headphone_sense_in(hp), .sense_in(sense),
    .sda_o(sda_o), .sda_oe(sda_oe), .int_n(int_n), .ctrl(ctrl));
  // ========
  // Model
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic hpm();
    return mdl[3][2] ? mdl[3][4] : hp;
  endfunction
  function automatic logic [7:0] ectl();
    return {mdl[1][3], mdl[1][4], mdl[2][0], mdl[3][1], mdl[3][2] & mdl[3][3], hpm(), hpm(), !ot && !mdl[2][0]};
  endfunction
  task automatic chk(input string w, input logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", w, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Register write
  task automatic wr(input logic [7:0] p, d);
    logic [2:0] a;
    @(posedge ref_clk);
    #1;
    mst.start_c();
    mst.put_byte({5'h12, strap, 1'b0}, a[2]);
    mst.put_byte(p, a[1]);
    mst.put_byte(d, a[0]);
    mst.stop_c();
    chk("wr ack", {5'h0, a}, 8'h07);
    if (p == 8'h02 && d[7:2] == 6'h3F) mdl = '{default: 8'h00};
    else if (p > 0 && p < 4) mdl[p[1:0]] = d;
  endtask
  // Register read with repeated start
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic [2:0] a;
    @(posedge ref_clk);
    #1;
    mst.start_c();
    mst.put_byte({5'h12, strap, 1'b0}, a[2]);
    mst.put_byte(p, a[1]);
    mst.start_c();
    mst.put_byte({5'h12, strap, 1'b1}, a[0]);
    mst.get_byte(1'b1, d);
    mst.stop_c();
    chk("rd ack", {5'h0, a}, 8'h07);
    ie = 1'b1;
  endtask
  // Foreign address must go unanswered
  task automatic probe(input logic [7:0] a);
    logic k;
    @(posedge ref_clk);
    #1;
    mst.start_c();
    mst.put_byte(a, k);
    mst.stop_c();
    chk("foreign ack", {7'h0, k}, 8'h00);
  endtask
  // Sense inputs, thermal flag and event tracking
  task automatic set_in(input logic h, input logic [7:0] t);
    @(posedge ref_clk);
    #1;
    lfsr = nxt(lfsr);
    if (h != hp && !mdl[3][2]) ie = 1'b0;
    hp = h;
    sense = {t, lfsr[3:0]};
    if (t > 8'hA0) ot = 1'b1;
    else if (t <= 8'h91) ot = 1'b0;
  endtask
  // Settle, compare outputs and all registers
  task automatic sweep();
    logic [7:0] d;
    repeat (12) @(posedge ref_clk);
    chk("ctrl", ctrl, ectl());
    chk("int_n", {7'h0, int_n}, {7'h0, ie});
    rd(8'h00, d);
    chk("status", d & 8'hFC, {ot, sense[3:0], hpm(), 2'h0});
    for (int p = 1; p < 4; p++) begin
      rd(p[7:0], d);
      chk("reg", d & msk[p], mdl[p] & msk[p]);
    end
  endtask
  // ========
  // Main sequence
  initial begin
    logic [7:0] d;
    repeat (2) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    sweep();
    $display("test 1 done");
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      wr(8'h01, {lfsr[7:5], i[1:0], lfsr[2:0]});
      sweep();
    end
    $display("test 2 done");
    for (int i = 0; i < 16; i++) begin
      set_in(lfsr[9], 8'h19);
      wr(8'h03, {lfsr[7:5], i[3:0], lfsr[0]});
      sweep();
    end
    $display("test 3 done");
    // Event held over a write, freed by a read
    wr(8'h03, 8'h00);
    set_in(!hp, 8'h19);
    wr(8'h01, 8'h18);
    sweep();
    sweep();
    $display("test 4 done");
    // Shutdown, then the reset pattern
    wr(8'h02, 8'h01);
    sweep();
    wr(8'h03, 8'h1E);
    wr(8'h02, 8'hFC);
    sweep();
    $display("test 5 done");
    for (int i = 0; i < 4; i++) begin
      set_in(hp, tmp[i]);
      sweep();
    end
    $display("test 6 done");
    probe(8'h90);
    probe(8'h00);
    probe(8'hF0);
    wr(8'h05, 8'hAA);
    rd(8'h05, d);
    chk("unmapped", d, 8'h00);
    sweep();
    $display("test 7 done");
    // Mid-run reset with a new strap value
    @(posedge ref_clk);
    #1;
    reset_n = 1'b0;
    lfsr = nxt(lfsr);
    strap = strap ^ {lfsr[0], 1'b1};
    repeat (2) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    mdl = '{default: 8'h00};
    ie = 1'b1;
    ot = 1'b0;
    repeat (2) @(posedge ref_clk);
    wr(8'h03, 8'h16);
    sweep();
    probe({5'h12, ~strap, 1'b0});
    $display("test 8 done");
    end_sim();
  end
  // Hang guard
  initial begin
    #5000000;
    err_total++;
    end_sim();
  end
endmodule
